// *** design/cmd_pkg.sv ***
`default_nettype none
package cmd_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NODES = 8;
    localparam int NODE_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CYCLE_INFO = 8'h00;
    localparam logic [7:0] OFS_CYCLE_DURATION = 8'h04;
    localparam logic [7:0] OFS_STATE_WORD0 = 8'h08;
    localparam logic [7:0] OFS_STATE_WORD1 = 8'h0C;
    localparam logic [7:0] OFS_STATE_WORD2 = 8'h10;
    localparam logic [7:0] OFS_STATE_WORD3 = 8'h14;
    localparam logic [7:0] OFS_INCOMPLETE = 8'h18;
    localparam logic [7:0] OFS_BUS_LOAD = 8'h1C;
    localparam logic [7:0] OFS_NODE_SELECT = 8'h20;
    localparam logic [7:0] OFS_NODE_STATE = 8'h24;
    localparam logic [7:0] OFS_DIAG_CHANGE = 8'h28;
    localparam logic [7:0] OFS_EMCY_COUNT = 8'h2C;
    localparam logic [7:0] OFS_NODE_CONFIG = 8'h30;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CI_COUNT_LSB = 0;
    localparam int CI_ERROR_LSB = 8;
    localparam int W1_RXERR_LSB = 0;
    localparam int W1_TXERR_LSB = 8;
    localparam int W2_BUS_OFF = 0;
    localparam int W2_WARNING = 1;
    localparam int W2_RXQ_OVF = 2;
    localparam int W2_HIQ_OVF = 3;
    localparam int W2_LOQ_OVF = 4;
    localparam int W2_SEND_ERR = 5;
    localparam int W2_SYNC_TOGGLE = 15;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NODES-1:0] RST_NODE_CONFIG = 8'h00;
    localparam logic [NODE_W-1:0] RST_NODE_SELECT = 3'h0;

    // ------------------------------------------------------------
    // Deferred diagnostic clear threshold, bytes
    // ------------------------------------------------------------
    localparam logic [15:0] DIAG_MIN_READ_LEN = 16'd106;

    // ------------------------------------------------------------
    // Master operating state codes
    // ------------------------------------------------------------
    localparam logic [15:0] MS_RUN = 16'h0000;
    localparam logic [15:0] MS_RESET = 16'h0001;
    localparam logic [15:0] MS_OFFLINE = 16'h0002;
    localparam logic [15:0] MS_STOPPED = 16'h0003;

    typedef enum logic [1:0] {
        CMD_MODE_RUN,
        CMD_MODE_RESET,
        CMD_MODE_OFFLINE,
        CMD_MODE_STOPPED
    } cmd_mode_t;

    // ------------------------------------------------------------
    // Node conditions reported by the protocol engine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NC_OK,
        CMD_NC_DEACTIVATED,
        CMD_NC_NOT_FOUND,
        CMD_NC_SDO_SYNTAX,
        CMD_NC_SDO_MISMATCH,
        CMD_NC_STARTUP,
        CMD_NC_BUS_OFF,
        CMD_NC_PREOP_REPORTED,
        CMD_NC_SEVERE_FAULT,
        CMD_NC_GUARD_TOGGLE,
        CMD_NC_TPDO_SHORT,
        CMD_NC_TPDO_MISSING,
        CMD_NC_TPDO_INCOMPLETE,
        CMD_NC_RPDO_INCOMPLETE,
        CMD_NC_PREOP,
        CMD_NC_STOPPED
    } cmd_node_cond_t;

    // Node communication state codes
    localparam logic [7:0] NS_OK = 8'h00;
    localparam logic [7:0] NS_DEACTIVATED = 8'h01;
    localparam logic [7:0] NS_NOT_FOUND = 8'h02;
    localparam logic [7:0] NS_SDO_SYNTAX = 8'h04;
    localparam logic [7:0] NS_SDO_MISMATCH = 8'h05;
    localparam logic [7:0] NS_STARTUP = 8'h08;
    localparam logic [7:0] NS_BUS_OFF = 8'h0B;
    localparam logic [7:0] NS_PREOP_REPORTED = 8'h0C;
    localparam logic [7:0] NS_SEVERE_FAULT = 8'h0D;
    localparam logic [7:0] NS_GUARD_TOGGLE = 8'h0E;
    localparam logic [7:0] NS_TPDO_SHORT = 8'h14;
    localparam logic [7:0] NS_TPDO_MISSING = 8'h16;
    localparam logic [7:0] NS_TPDO_INCOMPLETE = 8'h17;
    localparam logic [7:0] NS_RPDO_INCOMPLETE = 8'h80;
    localparam logic [7:0] NS_PREOP = 8'h81;
    localparam logic [7:0] NS_STOPPED = 8'h82;

    typedef enum logic {
        CMD_BUS_IDLE,
        CMD_BUS_BUSY
    } cmd_bus_state_t;
endpackage
`default_nettype wire

// *** design/cmd_diag_status.sv ***
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module cmd_diag_status
    import cmd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bus_cycle_start,
    input wire logic bus_cycle_done,
    input wire logic task_cycle_start,
    input wire logic [1:0] master_mode,
    input wire logic [7:0] receive_error_count,
    input wire logic [7:0] transmit_error_count,
    input wire logic bus_off,
    input wire logic warning_limit,
    input wire logic rx_queue_overflow,
    input wire logic hi_queue_overflow,
    input wire logic lo_queue_overflow,
    input wire logic send_error,
    input wire logic sync_sent,
    input wire logic [7:0] bus_load_in,
    input wire logic node_cond_valid,
    input wire logic [NODE_W-1:0] node_cond_index,
    input wire logic [3:0] node_cond,
    input wire logic emergency_received,
    input wire logic [NODE_W-1:0] emergency_node,
    input wire logic diag_changed,
    input wire logic [NODE_W-1:0] diag_changed_node,
    input wire logic diag_read_done,
    input wire logic [NODE_W-1:0] diag_read_node,
    input wire logic diag_read_deferred,
    input wire logic [15:0] diag_read_length
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] node_code(input logic [3:0] cond);
        logic [7:0] code;
        code = NS_OK;
        unique case (cmd_node_cond_t'(cond))
            CMD_NC_OK: code = NS_OK;
            CMD_NC_DEACTIVATED: code = NS_DEACTIVATED;
            CMD_NC_NOT_FOUND: code = NS_NOT_FOUND;
            CMD_NC_SDO_SYNTAX: code = NS_SDO_SYNTAX;
            CMD_NC_SDO_MISMATCH: code = NS_SDO_MISMATCH;
            CMD_NC_STARTUP: code = NS_STARTUP;
            CMD_NC_BUS_OFF: code = NS_BUS_OFF;
            CMD_NC_PREOP_REPORTED: code = NS_PREOP_REPORTED;
            CMD_NC_SEVERE_FAULT: code = NS_SEVERE_FAULT;
            CMD_NC_GUARD_TOGGLE: code = NS_GUARD_TOGGLE;
            CMD_NC_TPDO_SHORT: code = NS_TPDO_SHORT;
            CMD_NC_TPDO_MISSING: code = NS_TPDO_MISSING;
            CMD_NC_TPDO_INCOMPLETE: code = NS_TPDO_INCOMPLETE;
            CMD_NC_RPDO_INCOMPLETE: code = NS_RPDO_INCOMPLETE;
            CMD_NC_PREOP: code = NS_PREOP;
            CMD_NC_STOPPED: code = NS_STOPPED;
        endcase
        return code;
    endfunction

    function automatic logic [15:0] mode_code(input logic [1:0] mode);
        logic [15:0] code;
        code = MS_RUN;
        unique case (cmd_mode_t'(mode))
            CMD_MODE_RUN: code = MS_RUN;
            CMD_MODE_RESET: code = MS_RESET;
            CMD_MODE_OFFLINE: code = MS_OFFLINE;
            CMD_MODE_STOPPED: code = MS_STOPPED;
        endcase
        return code;
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] cycle_count;
    logic [7:0] error_nodes;
    logic [15:0] incomplete_cycle_count;
    logic [15:0] master_state_word0;
    logic [15:0] master_state_word1;
    logic [15:0] master_state_word2;
    logic [15:0] bus_load_percent;
    logic [NODES-1:0] node_config;
    logic [NODE_W-1:0] node_select;
    logic [7:0] node_comm_state [NODES];
    logic [15:0] emergency_telegram_count [NODES];
    logic [NODES-1:0] diag_flag;
    cmd_bus_state_t bus_state;

    logic bus_req;
    logic wr_take;
    logic w2_clear_hit;
    logic [15:0] w2_clear_mask;
    logic [7:0] next_error_nodes;
    logic [DATA_W-1:0] next_readdata;

    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write & ~avs_waitrequest;
    assign w2_clear_hit = wr_take && (avs_address == OFS_STATE_WORD2);
    assign w2_clear_mask = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                            avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

    // ------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = '0;
        unique case (avs_address)
            OFS_CYCLE_INFO: begin
                next_readdata[CI_COUNT_LSB +: 8] = cycle_count;
                next_readdata[CI_ERROR_LSB +: 8] = error_nodes;
            end
            OFS_CYCLE_DURATION: next_readdata = '0;
            OFS_STATE_WORD0: next_readdata[15:0] = master_state_word0;
            OFS_STATE_WORD1: next_readdata[15:0] = master_state_word1;
            OFS_STATE_WORD2: next_readdata[15:0] = master_state_word2;
            OFS_STATE_WORD3: next_readdata[15:0] = bus_load_percent;
            OFS_INCOMPLETE: next_readdata[15:0] = incomplete_cycle_count;
            OFS_BUS_LOAD: next_readdata[15:0] = bus_load_percent;
            OFS_NODE_SELECT: next_readdata[NODE_W-1:0] = node_select;
            OFS_NODE_STATE: next_readdata[7:0] = node_comm_state[node_select];
            OFS_DIAG_CHANGE: next_readdata[0] = diag_flag[node_select];
            OFS_EMCY_COUNT: next_readdata[15:0] = emergency_telegram_count[node_select];
            OFS_NODE_CONFIG: next_readdata[NODES-1:0] = node_config;
            default: next_readdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // Software control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            node_select <= RST_NODE_SELECT;
            node_config <= RST_NODE_CONFIG;
        end else if (wr_take && avs_byteenable[0]) begin
            if (avs_address == OFS_NODE_SELECT) begin
                node_select <= avs_writedata[NODE_W-1:0];
            end
            if (avs_address == OFS_NODE_CONFIG) begin
                node_config <= avs_writedata[NODES-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus cycle tracking and cycle counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_state <= CMD_BUS_IDLE;
        end else if (bus_cycle_start) begin
            bus_state <= CMD_BUS_BUSY;
        end else if (bus_cycle_done) begin
            bus_state <= CMD_BUS_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cycle_count <= '0;
        end else if (bus_cycle_done) begin
            cycle_count <= cycle_count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            incomplete_cycle_count <= '0;
        end else if (task_cycle_start && bus_state == CMD_BUS_BUSY) begin
            incomplete_cycle_count <= incomplete_cycle_count + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Error node count
    // ------------------------------------------------------------
    always_comb begin
        next_error_nodes = '0;
        for (int i = 0; i < NODES; i++) begin
            if (node_config[i] && node_comm_state[i] != NS_OK) begin
                next_error_nodes = next_error_nodes + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            error_nodes <= '0;
        end else begin
            error_nodes <= next_error_nodes;
        end
    end

    // ------------------------------------------------------------
    // Master state words
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            master_state_word0 <= MS_RUN;
            master_state_word1 <= '0;
            bus_load_percent <= '0;
        end else begin
            master_state_word0 <= mode_code(master_mode);
            master_state_word1[W1_RXERR_LSB +: 8] <= receive_error_count;
            master_state_word1[W1_TXERR_LSB +: 8] <= transmit_error_count;
            bus_load_percent <= {8'h00, bus_load_in};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            master_state_word2 <= '0;
        end else begin
            master_state_word2[W2_BUS_OFF] <= bus_off;
            master_state_word2[W2_WARNING] <= warning_limit;
            // Sticky flags, a new event beats a clear
            master_state_word2[W2_RXQ_OVF] <= rx_queue_overflow |
                (master_state_word2[W2_RXQ_OVF] & ~(w2_clear_hit & w2_clear_mask[W2_RXQ_OVF]));
            master_state_word2[W2_HIQ_OVF] <= hi_queue_overflow |
                (master_state_word2[W2_HIQ_OVF] & ~(w2_clear_hit & w2_clear_mask[W2_HIQ_OVF]));
            master_state_word2[W2_LOQ_OVF] <= lo_queue_overflow |
                (master_state_word2[W2_LOQ_OVF] & ~(w2_clear_hit & w2_clear_mask[W2_LOQ_OVF]));
            master_state_word2[W2_SEND_ERR] <= send_error |
                (master_state_word2[W2_SEND_ERR] & ~(w2_clear_hit & w2_clear_mask[W2_SEND_ERR]));
            master_state_word2[W2_SYNC_TOGGLE-1:W2_SEND_ERR+1] <= '0;
            if (sync_sent) begin
                master_state_word2[W2_SYNC_TOGGLE] <= ~master_state_word2[W2_SYNC_TOGGLE];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-node state, emergency counters and change flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NODES; i++) begin
                node_comm_state[i] <= NS_OK;
            end
        end else if (node_cond_valid) begin
            node_comm_state[node_cond_index] <= node_code(node_cond);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NODES; i++) begin
                emergency_telegram_count[i] <= '0;
            end
        end else if (emergency_received) begin
            emergency_telegram_count[emergency_node] <=
                emergency_telegram_count[emergency_node] + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            diag_flag <= '0;
        end else begin
            for (int i = 0; i < NODES; i++) begin
                if ((diag_changed && diag_changed_node == NODE_W'(i)) ||
                    (node_cond_valid && node_cond_index == NODE_W'(i) &&
                     node_code(node_cond) != node_comm_state[i])) begin
                    diag_flag[i] <= 1'b1;
                end else if (diag_read_done && diag_read_node == NODE_W'(i) &&
                             (!diag_read_deferred ||
                              diag_read_length >= DIAG_MIN_READ_LEN)) begin
                    diag_flag[i] <= 1'b0;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** bench/cmd_diag_status_asserts.sv ***
`default_nettype none
module cmd_diag_status_asserts
    import cmd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] master_mode,
    input wire logic [7:0] receive_error_count,
    input wire logic [7:0] transmit_error_count,
    input wire logic bus_off,
    input wire logic warning_limit,
    input wire logic [7:0] bus_load_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Level inputs held still long enough to be read back
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic [27:0] lv;
    wire logic rd_end;
    wire logic calm;
    logic [27:0] lv_q;
    logic [1:0] calm_cnt;
    assign lv = {master_mode, receive_error_count, transmit_error_count,
                 bus_off, warning_limit, bus_load_in};
    assign rd_end = avs_read && !avs_waitrequest;
    assign calm = calm_cnt >= 2'd2 && lv == lv_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lv_q <= '0;
            calm_cnt <= 2'd0;
        end else begin
            lv_q <= lv;
            calm_cnt <= (lv != lv_q) ? 2'd0 : (calm_cnt == 2'd3) ? 2'd3 : calm_cnt + 2'd1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_wait_answer:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_single:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_unmapped_zero:
        assert property (rd_end && avs_address > OFS_NODE_CONFIG |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_duration_zero:
        assert property (rd_end && avs_address == OFS_CYCLE_DURATION |-> avs_readdata == '0)
        else $error("reserved duration field not zero");
    a_mode_word:
        assert property (rd_end && calm && avs_address == OFS_STATE_WORD0
            |-> avs_readdata == {30'h0, master_mode})
        else $error("state word 0 wrong");
    a_error_counts:
        assert property (rd_end && calm && avs_address == OFS_STATE_WORD1
            |-> avs_readdata == {16'h0000, transmit_error_count, receive_error_count})
        else $error("state word 1 wrong");
    a_bus_load:
        assert property (rd_end && calm && (avs_address == OFS_STATE_WORD3
            || avs_address == OFS_BUS_LOAD) |-> avs_readdata == {24'h00_0000, bus_load_in})
        else $error("bus load wrong");
    a_word2_levels:
        assert property (rd_end && calm && avs_address == OFS_STATE_WORD2
            |-> avs_readdata[1:0] == {warning_limit, bus_off}
            && avs_readdata[14:6] == 9'h000 && avs_readdata[31:16] == 16'h0000)
        else $error("state word 2 levels wrong");
    c_write: cover property (avs_write && !avs_waitrequest);
    c_node_read: cover property (rd_end && avs_address == OFS_NODE_STATE);
    c_sync_seen: cover property (rd_end && avs_address == OFS_STATE_WORD2 && avs_readdata[15]);
endmodule
bind cmd_diag_status cmd_diag_status_asserts cmd_diag_status_asserts_inst (
    .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .master_mode, .receive_error_count, .transmit_error_count,
    .bus_off, .warning_limit, .bus_load_in);
`default_nettype wire

// *** bench/cmd_slave_model.sv ***
`default_nettype none
module cmd_slave_model
    import cmd_pkg::*;
(
    input wire logic clk_sys,
    output logic node_cond_valid,
    output logic [NODE_W-1:0] node_cond_index,
    output logic [3:0] node_cond,
    output logic emergency_received,
    output logic [NODE_W-1:0] emergency_node
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        node_cond_valid = 1'b0;
        node_cond_index = '0;
        node_cond = 4'h0;
        emergency_received = 1'b0;
        emergency_node = '0;
    end
    // Node condition after a response delay; released lines show the inverse
    task automatic report(input logic [NODE_W-1:0] n, input logic [3:0] c, input int gap);
        repeat (gap) @(posedge clk_sys);
        node_cond_valid <= 1'b1;
        node_cond_index <= n;
        node_cond <= c;
        @(posedge clk_sys);
        node_cond_valid <= 1'b0;
        node_cond_index <= ~n;
        node_cond <= ~c;
        @(posedge clk_sys);
    endtask
    task automatic emcy(input logic [NODE_W-1:0] n, input int gap);
        repeat (gap) @(posedge clk_sys);
        emergency_received <= 1'b1;
        emergency_node <= n;
        @(posedge clk_sys);
        emergency_received <= 1'b0;
        emergency_node <= ~n;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// *** bench/test_canopen_master_diag_status.sv ***
`default_nettype none
module test_canopen_master_diag_status
    import cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, bus_off, warning_limit;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [1:0] master_mode;
    logic [7:0] rx_cnt, tx_cnt, bus_load_in, r8, t8, l8;
    logic [9:0] ev;
    logic [NODE_W-1:0] nci, emn, sel_node;
    logic [3:0] nc;
    logic ncv, emv, defer;
    logic [15:0] rd_len;
    logic [31:0] exp_q[$];
    int errors, num_checks;
    logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0B, 8'h0C,
                               8'h0D, 8'h0E, 8'h14, 8'h16, 8'h17, 8'h80, 8'h81, 8'h82};
    cmd_diag_status cmd_diag_status_inst (.clk_sys, .rstn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .bus_cycle_start(ev[0]), .bus_cycle_done(ev[1]), .task_cycle_start(ev[2]),
        .master_mode, .receive_error_count(rx_cnt), .transmit_error_count(tx_cnt),
        .bus_off, .warning_limit, .rx_queue_overflow(ev[3]), .hi_queue_overflow(ev[4]),
        .lo_queue_overflow(ev[5]), .send_error(ev[6]), .sync_sent(ev[7]), .bus_load_in,
        .node_cond_valid(ncv), .node_cond_index(nci), .node_cond(nc),
        .emergency_received(emv), .emergency_node(emn), .diag_changed(ev[8]),
        .diag_changed_node(sel_node), .diag_read_done(ev[9]), .diag_read_node(sel_node),
        .diag_read_deferred(defer), .diag_read_length(rd_len));
    cmd_slave_model cmd_slave_model_inst (.clk_sys, .node_cond_valid(ncv),
        .node_cond_index(nci), .node_cond(nc), .emergency_received(emv), .emergency_node(emn));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Bus, event and scoring tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clk_sys);
        ev <= '0;
        @(posedge clk_sys);
    endtask
    // Read data compared against the oldest note
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(avs_readdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rstn, avs_read, avs_write, bus_off, warning_limit, defer} = '0;
        {avs_address, avs_writedata, master_mode, rx_cnt, tx_cnt, bus_load_in} = '0;
        {ev, sel_node, rd_len} = '0;
        void'($urandom(72452));
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(OFS_CYCLE_INFO, 32'h0000_0000);
        rd(OFS_NODE_CONFIG, 32'h0000_0000);
        rd(OFS_CYCLE_DURATION, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            master_mode <= 2'(m);
            repeat (2) @(posedge clk_sys);
            rd(OFS_STATE_WORD0, 32'(m));
        end
        bus(OFS_STATE_WORD0, 1'b1, 32'hFFFF_FFFF);
        rd(OFS_STATE_WORD0, 32'h0000_0003);
        repeat (4) begin
            r8 = 8'($urandom);
            t8 = 8'($urandom);
            l8 = 8'($urandom_range(100));
            rx_cnt <= r8;
            tx_cnt <= t8;
            bus_load_in <= l8;
            repeat (2) @(posedge clk_sys);
            rd(OFS_STATE_WORD1, {16'h0000, t8, r8});
            rd(OFS_STATE_WORD3, {24'h00_0000, l8});
            rd(OFS_BUS_LOAD, {24'h00_0000, l8});
        end
        bus_off <= 1'b1;
        warning_limit <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(OFS_STATE_WORD2, 32'h0000_0003);
        bus_off <= 1'b0;
        warning_limit <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(OFS_STATE_WORD2, 32'h0000_0000);
        for (int b = 3; b < 7; b++) begin
            pulse(b);
            rd(OFS_STATE_WORD2, 32'(1 << (b - 1)));
            bus(OFS_STATE_WORD2, 1'b1, 32'(1 << (b - 1)));
            rd(OFS_STATE_WORD2, 32'h0000_0000);
        end
        pulse(7);
        rd(OFS_STATE_WORD2, 32'h0000_8000);
        pulse(7);
        rd(OFS_STATE_WORD2, 32'h0000_0000);
        repeat (300) begin
            pulse(0);
            pulse(1);
        end
        rd(OFS_CYCLE_INFO, 32'h0000_002C);
        pulse(0);
        pulse(2);
        pulse(1);
        pulse(2);
        rd(OFS_INCOMPLETE, 32'h0000_0001);
        bus(OFS_NODE_CONFIG, 1'b1, 32'h0000_0008);
        sel_node <= 3'd3;
        bus(OFS_NODE_SELECT, 1'b1, 32'h0000_0003);
        cmd_slave_model_inst.report(3'd5, 4'h2, 0);
        for (int i = 0; i < 16; i++) begin
            cmd_slave_model_inst.report(3'd3, 4'(i), i % 3);
            rd(OFS_NODE_STATE, {24'h00_0000, codes[i]});
            rd(OFS_CYCLE_INFO, {23'h00_0000, codes[i] != 8'h00, 8'h2D});
        end
        rd(OFS_DIAG_CHANGE, 32'h0000_0001);
        pulse(9);
        rd(OFS_DIAG_CHANGE, 32'h0000_0000);
        pulse(8);
        rd(OFS_DIAG_CHANGE, 32'h0000_0001);
        defer <= 1'b1;
        rd_len <= 16'd105;
        pulse(9);
        rd(OFS_DIAG_CHANGE, 32'h0000_0001);
        rd_len <= 16'd106;
        pulse(9);
        rd(OFS_DIAG_CHANGE, 32'h0000_0000);
        for (int k = 0; k < 3; k++) cmd_slave_model_inst.emcy(3'd3, k);
        cmd_slave_model_inst.emcy(3'd5, 0);
        rd(OFS_EMCY_COUNT, 32'h0000_0003);
        end_sim();
    end
endmodule
`default_nettype wire
